// ---- design/mps_regs.svh ----
// Register map, reset values and setting codes of the motor profile selector
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH

`define MPS_A_MOTOR1   8'h00
`define MPS_A_MOTOR2   8'h04
`define MPS_A_EXTDISP  8'h08
`define MPS_A_THERM    8'h0c
`define MPS_A_PID      8'h10
`define MPS_A_OPMODE   8'h14
`define MPS_A_ITFS0    8'h18
`define MPS_A_BOOST    8'h2c
`define MPS_A_STATUS   8'h30
`define MPS_A_IRQSTAT  8'h34
`define MPS_A_IRQMASK  8'h38

`define MPS_NONE       14'h270f
`define MPS_ZERO14     14'h0000
`define MPS_MP_STD     6'h00
`define MPS_MP_CT      6'h01
`define MPS_MP_TSTD    6'h03
`define MPS_MP_TCT     6'h0d
`define MPS_MP_TSMALL  6'h17
`define MPS_MP_HE      6'h28
`define MPS_MP_THE     6'h2b
`define MPS_MP_CTALT   6'h32
`define MPS_MP_TCTALT  6'h35
`define MPS_SM_CT      14'h0001
`define MPS_FN_SECOND  14'h0003
`define MPS_FN_CURRENT 14'h0004
`define MPS_OPM_RST    4'h0
`define MPS_OPM_3      4'h3
`define MPS_OPM_4      4'h4
`define MPS_BOOST_STD  8'h03
`define MPS_BRAKE_STD  8'h04
`define MPS_BOOST_CT   8'h02
`define MPS_BRAKE_CT   8'h02
`define MPS_PCT_ALARM  7'h55
`define MPS_PCT_FULL   7'h64

`define MPS_IRQ_REJECT 0
`define MPS_IRQ_ALARM  1
`define MPS_IRQ_SFS    2
`define MPS_ST_SECOND  0
`define MPS_ST_T2      1
`define MPS_ST_T4      2
`define MPS_ST_ALARM   3
`define MPS_ST_SFS     4
`define MPS_ST_CURSEL  5
`define MPS_ST_TUNE    6

`endif

// ---- design/mps_pkg.sv ----
// Types shared by the motor profile selector modules
package mps_pkg;

  typedef enum logic [1:0] {
    MPS_CURVE_STD    = 2'b00,
    MPS_CURVE_CT     = 2'b01,
    MPS_CURVE_HE     = 2'b10,
    MPS_CURVE_CT_ALT = 2'b11
  } mps_curve_t;

  typedef logic [5:0] mps_code_t;

endpackage

// ---- design/mps_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module mps_sync
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [4:0] i_pin,
  output logic      [4:0] o_level
);
  logic [4:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // Stage one feeds only stage two; a change counts once stages two and three agree
  always_comb
  begin
    lvl_d = lvl_q;
    for (int k = 0; k < 5; k++)
    begin
      if (s2_q[k] == s3_q[k])
        lvl_d[k] = s3_q[k];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s1_q  <= 5'h00;
      s2_q  <= 5'h00;
      s3_q  <= 5'h00;
      lvl_q <= 5'h00;
    end
    else
    begin
      s1_q  <= i_pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;
endmodule
`default_nettype wire

// ---- design/mps_profile_decode.sv ----
// Active motor profile selection and thermal curve decode
`timescale 1ns/1ps
`default_nettype none
`include "mps_regs.svh"
module mps_profile_decode
(
  input  wire logic [5:0]        i_first,
  input  wire logic [13:0]       i_second,
  input  wire logic              i_second_fn,
  output mps_pkg::mps_code_t     o_code,
  output mps_pkg::mps_curve_t    o_curve,
  output logic                   o_autotune,
  output logic                   o_const_torque,
  output logic                   o_second_active
);
  import mps_pkg::*;

  function automatic mps_curve_t curve_of(input mps_code_t c);
    case (c)
      `MPS_MP_CT, `MPS_MP_TCT:     curve_of = MPS_CURVE_CT;
      `MPS_MP_HE, `MPS_MP_THE:     curve_of = MPS_CURVE_HE;
      `MPS_MP_CTALT, `MPS_MP_TCTALT: curve_of = MPS_CURVE_CT_ALT;
      default:                     curve_of = MPS_CURVE_STD;
    endcase
  endfunction

  always_comb
  begin
    o_second_active = (i_second != `MPS_NONE) && i_second_fn;
    o_code          = o_second_active ? i_second[5:0] : i_first;
    o_curve         = curve_of(o_code);
    o_autotune      = (o_code == `MPS_MP_TSTD) || (o_code == `MPS_MP_TCT) ||
                      (o_code == `MPS_MP_TSMALL) || (o_code == `MPS_MP_THE) ||
                      (o_code == `MPS_MP_TCTALT);
    o_const_torque  = (o_curve == MPS_CURVE_CT) || (o_curve == MPS_CURVE_CT_ALT);
  end
endmodule
`default_nettype wire

// ---- design/mps_top.sv ----
// Motor profile selector: APB settings, terminal routing, prealarm, interrupt
`timescale 1ns/1ps
`default_nettype none
`include "mps_regs.svh"
module mps_top
(
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic [4:0]        i_terminal,
  input  wire logic              i_external_mode,
  input  wire logic              i_auto_boost_rating,
  input  wire logic [15:0]       i_thermal_cum,
  input  wire logic [15:0]       i_motor1_current,
  input  wire logic [15:0]       i_motor2_current,
  output logic                   o_t2_freq_enable,
  output logic                   o_t4_freq_enable,
  output logic                   o_second_function,
  output logic                   o_second_motor_active,
  output mps_pkg::mps_curve_t    o_thermal_curve,
  output mps_pkg::mps_code_t     o_motor_const_sel,
  output logic                   o_autotune_profile,
  output logic                   o_thermal_prealarm,
  output logic      [7:0]        o_torque_boost_level,
  output logic      [7:0]        o_dc_brake_voltage,
  output logic                   o_irq
);
  import mps_pkg::*;

  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  function automatic logic first_ok(input logic [31:0] v);
    first_ok = (v[31:6] == 26'h0) &&
               ((v[5:0] == `MPS_MP_STD) || (v[5:0] == `MPS_MP_CT) ||
                (v[5:0] == `MPS_MP_TSTD) || (v[5:0] == `MPS_MP_TCT) ||
                (v[5:0] == `MPS_MP_TSMALL) || (v[5:0] == `MPS_MP_HE) ||
                (v[5:0] == `MPS_MP_THE) || (v[5:0] == `MPS_MP_CTALT) ||
                (v[5:0] == `MPS_MP_TCTALT));
  endfunction

  function automatic logic second_ok(input logic [31:0] v);
    second_ok = (v[31:14] == 18'h0) && ((v[13:0] == `MPS_ZERO14) ||
                (v[13:0] == `MPS_SM_CT) || (v[13:0] == `MPS_NONE));
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `MPS_A_IRQMASK);
  endfunction

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  logic [5:0]  motor1_q, motor1_d;
  logic [13:0] motor2_q, motor2_d;
  logic [13:0] extdisp_q, extdisp_d;
  logic [13:0] therm_q, therm_d;
  logic [13:0] pid_q, pid_d;
  logic [3:0]  opmode_q, opmode_d;
  logic [13:0] itfs_q [5];
  logic [13:0] itfs_d [5];
  logic [7:0]  boost_q, boost_d;
  logic [7:0]  brake_q, brake_d;
  logic [2:0]  irq_stat_q, irq_stat_d;
  logic [2:0]  irq_mask_q, irq_mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic        t2_q, t2_d, t4_q, t4_d, sfs_q, sfs_d, cursel_d;
  logic        second_q, tune_q, alarm_q, alarm_d;
  mps_curve_t  curve_q;
  mps_code_t   code_q;

  logic [4:0]  term_lvl;
  logic        wr, rd_access, wr_m1, wr_m2, reject, m1_ok;
  logic        sec_act, tune_act, ct_act;
  mps_curve_t  curve_act;
  mps_code_t   code_act;
  logic [22:0] cum_scaled, lim_scaled;
  logic [15:0] cur_act;
  logic [31:0] rd_mux;

  mps_sync u_sync
  (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pin   (i_terminal),
    .o_level (term_lvl)
  );

  mps_profile_decode u_decode
  (
    .i_first         (motor1_q),
    .i_second        (motor2_q),
    .i_second_fn     (sfs_q),
    .o_code          (code_act),
    .o_curve         (curve_act),
    .o_autotune      (tune_act),
    .o_const_torque  (ct_act),
    .o_second_active (sec_act)
  );

  //----------------------------------------------------------------------------
  // APB access decode
  //----------------------------------------------------------------------------
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped(i_paddr);
  assign o_prdata  = prdata_q;
  assign wr        = i_psel && i_penable && i_pwrite && mapped(i_paddr);
  assign rd_access = i_psel && i_penable && !i_pwrite;
  assign wr_m1     = wr && (i_paddr == `MPS_A_MOTOR1);
  assign wr_m2     = wr && (i_paddr == `MPS_A_MOTOR2);
  // A locked or out-of-range profile write keeps the old value
  assign m1_ok     = (extdisp_q == `MPS_ZERO14) && first_ok(i_pwdata);
  assign reject    = (wr_m1 && !m1_ok) || (wr_m2 && ((extdisp_q != `MPS_ZERO14) ||
                     !second_ok(i_pwdata)));

  always_comb
  begin
    rd_mux = 32'h0;
    case (i_paddr)
      `MPS_A_MOTOR1:  rd_mux[5:0] = motor1_q;
      `MPS_A_MOTOR2:  rd_mux[13:0] = motor2_q;
      `MPS_A_EXTDISP: rd_mux[13:0] = extdisp_q;
      `MPS_A_THERM:   rd_mux[13:0] = therm_q;
      `MPS_A_PID:     rd_mux[13:0] = pid_q;
      `MPS_A_OPMODE:  rd_mux[3:0] = opmode_q;
      `MPS_A_BOOST:   rd_mux[15:0] = {brake_q, boost_q};
      `MPS_A_STATUS:
      begin
        rd_mux[`MPS_ST_SECOND] = second_q;
        rd_mux[`MPS_ST_T2]     = t2_q;
        rd_mux[`MPS_ST_T4]     = t4_q;
        rd_mux[`MPS_ST_ALARM]  = alarm_q;
        rd_mux[`MPS_ST_SFS]    = sfs_q;
        rd_mux[`MPS_ST_CURSEL] = cursel_d;
        rd_mux[`MPS_ST_TUNE]   = tune_q;
      end
      `MPS_A_IRQSTAT: rd_mux[2:0] = irq_stat_q;
      `MPS_A_IRQMASK: rd_mux[2:0] = irq_mask_q;
      default:
      begin
        for (int k = 0; k < 5; k++)
        begin
          if (i_paddr == `MPS_A_ITFS0 + 8'(4 * k))
            rd_mux[13:0] = itfs_q[k];
        end
      end
    endcase
  end

  //----------------------------------------------------------------------------
  // Terminal routing and second function
  //----------------------------------------------------------------------------
  always_comb
  begin
    sfs_d = 1'b0;
    cursel_d = 1'b0;
    for (int k = 0; k < 5; k++)
    begin
      if (term_lvl[k] && (itfs_q[k] == `MPS_FN_SECOND))
        sfs_d = 1'b1;
      if (term_lvl[k] && (itfs_q[k] == `MPS_FN_CURRENT))
        cursel_d = 1'b1;
    end
    // PTC input or PID feedback both claim terminal 2
    t2_d = (therm_q == `MPS_NONE) && (pid_q == `MPS_ZERO14);
    if ((pid_q == `MPS_ZERO14) && (i_external_mode || (opmode_q == `MPS_OPM_4)))
      t4_d = 1'b1;
    else
      t4_d = cursel_d;
  end

  //----------------------------------------------------------------------------
  // Prealarm: compare in percent so no divider is needed
  //----------------------------------------------------------------------------
  always_comb
  begin
    cur_act    = second_q ? i_motor2_current : i_motor1_current;
    cum_scaled = i_thermal_cum * `MPS_PCT_FULL;
    lim_scaled = cur_act * `MPS_PCT_ALARM;
    // A zero current setting means thermal protection is off
    alarm_d    = (cur_act != 16'h0) && (cum_scaled >= lim_scaled);
  end

  //----------------------------------------------------------------------------
  // Settings next state
  //----------------------------------------------------------------------------
  always_comb
  begin
    motor1_d   = motor1_q;
    motor2_d   = motor2_q;
    extdisp_d  = extdisp_q;
    therm_d    = therm_q;
    pid_d      = pid_q;
    opmode_d   = opmode_q;
    boost_d    = boost_q;
    brake_d    = brake_q;
    irq_mask_d = irq_mask_q;
    prdata_d   = prdata_q;
    for (int k = 0; k < 5; k++)
      itfs_d[k] = itfs_q[k];
    if (i_psel && !i_penable)
      prdata_d = rd_mux;
    if (wr_m1 && m1_ok)
    begin
      motor1_d = i_pwdata[5:0];
      if (i_auto_boost_rating)
      begin
        if (first_ok(i_pwdata) && ((i_pwdata[5:0] == `MPS_MP_CT) ||
            (i_pwdata[5:0] == `MPS_MP_TCT) || (i_pwdata[5:0] == `MPS_MP_CTALT) ||
            (i_pwdata[5:0] == `MPS_MP_TCTALT)))
        begin
          boost_d = `MPS_BOOST_CT;
          brake_d = `MPS_BRAKE_CT;
        end
        else
        begin
          boost_d = `MPS_BOOST_STD;
          brake_d = `MPS_BRAKE_STD;
        end
      end
    end
    if (wr_m2 && !reject)
      motor2_d = i_pwdata[13:0];
    if (wr)
    begin
      case (i_paddr)
        `MPS_A_EXTDISP: extdisp_d = i_pwdata[13:0];
        `MPS_A_THERM:   therm_d = i_pwdata[13:0];
        `MPS_A_PID:     pid_d = i_pwdata[13:0];
        `MPS_A_OPMODE:  opmode_d = i_pwdata[3:0];
        `MPS_A_BOOST:
        begin
          boost_d = i_pwdata[7:0];
          brake_d = i_pwdata[15:8];
        end
        `MPS_A_IRQMASK: irq_mask_d = i_pwdata[2:0];
        default:
        begin
          for (int k = 0; k < 5; k++)
          begin
            if (i_paddr == `MPS_A_ITFS0 + 8'(4 * k))
              itfs_d[k] = i_pwdata[13:0];
          end
        end
      endcase
    end
    // Read clears, but an event in the same cycle still lands
    irq_stat_d = (rd_access && (i_paddr == `MPS_A_IRQSTAT)) ? 3'h0 : irq_stat_q;
    irq_stat_d[`MPS_IRQ_REJECT] = irq_stat_d[`MPS_IRQ_REJECT] | reject;
    irq_stat_d[`MPS_IRQ_ALARM]  = irq_stat_d[`MPS_IRQ_ALARM] | (alarm_d & ~alarm_q);
    irq_stat_d[`MPS_IRQ_SFS]    = irq_stat_d[`MPS_IRQ_SFS] | (sfs_d ^ sfs_q);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      motor1_q   <= `MPS_MP_STD;
      motor2_q   <= `MPS_NONE;
      extdisp_q  <= `MPS_ZERO14;
      therm_q    <= `MPS_NONE;
      pid_q      <= `MPS_ZERO14;
      opmode_q   <= `MPS_OPM_RST;
      boost_q    <= `MPS_BOOST_STD;
      brake_q    <= `MPS_BRAKE_STD;
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      prdata_q   <= 32'h0;
      for (int k = 0; k < 5; k++)
        itfs_q[k] <= `MPS_ZERO14;
    end
    else
    begin
      motor1_q   <= motor1_d;
      motor2_q   <= motor2_d;
      extdisp_q  <= extdisp_d;
      therm_q    <= therm_d;
      pid_q      <= pid_d;
      opmode_q   <= opmode_d;
      boost_q    <= boost_d;
      brake_q    <= brake_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      prdata_q   <= prdata_d;
      for (int k = 0; k < 5; k++)
        itfs_q[k] <= itfs_d[k];
    end
  end

  //----------------------------------------------------------------------------
  // Output registers
  //----------------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      t2_q     <= 1'b0;
      t4_q     <= 1'b0;
      sfs_q    <= 1'b0;
      second_q <= 1'b0;
      tune_q   <= 1'b0;
      alarm_q  <= 1'b0;
      curve_q  <= MPS_CURVE_STD;
      code_q   <= `MPS_MP_STD;
    end
    else
    begin
      t2_q     <= t2_d;
      t4_q     <= t4_d;
      sfs_q    <= sfs_d;
      second_q <= sec_act;
      tune_q   <= tune_act;
      alarm_q  <= alarm_d;
      curve_q  <= curve_act;
      code_q   <= code_act;
    end
  end

  assign o_t2_freq_enable      = t2_q;
  assign o_t4_freq_enable      = t4_q;
  assign o_second_function     = sfs_q;
  assign o_second_motor_active = second_q;
  assign o_thermal_curve       = curve_q;
  assign o_motor_const_sel     = code_q;
  assign o_autotune_profile    = tune_q;
  assign o_thermal_prealarm    = alarm_q;
  assign o_torque_boost_level  = boost_q;
  assign o_dc_brake_voltage    = brake_q;
  assign o_irq                 = |(irq_stat_q & irq_mask_q);

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_locked_wr;
    (wr_m1 || wr_m2) && (extdisp_q != `MPS_ZERO14);
  endsequence
  sequence s_bad_m1;
    wr_m1 && !first_ok(i_pwdata);
  endsequence

  t2_therm_a: assert property ((therm_q != `MPS_NONE) |=> !o_t2_freq_enable)
    else $error("terminal 2 enabled with thermistor in use");
  t2_pid_a: assert property ((pid_q != `MPS_ZERO14) |=> !o_t2_freq_enable)
    else $error("terminal 2 enabled under PID");
  t4_mode4_a: assert property ((pid_q == `MPS_ZERO14 && opmode_q == `MPS_OPM_4)
    |=> o_t4_freq_enable) else $error("terminal 4 not forced in mode 4");
  t4_mode3_a: assert property ((pid_q == `MPS_ZERO14 && opmode_q == `MPS_OPM_3
    && !i_external_mode) |=> (o_t4_freq_enable == $past(cursel_d)))
    else $error("terminal 4 not following current select");
  motor1_legal_a: assert property (first_ok({26'h0, motor1_q}))
    else $error("first profile holds an illegal code");
  curve_he_a: assert property ((motor1_q == `MPS_MP_HE && !sec_act)
    |=> o_thermal_curve == MPS_CURVE_HE) else $error("profile 40 curve wrong");
  tune_sel_a: assert property ((motor1_q == `MPS_MP_TSMALL && !sec_act)
    |=> o_autotune_profile) else $error("tuning profile not flagged");
  second_none_a: assert property ((motor2_q == `MPS_NONE) |=> !o_second_motor_active)
    else $error("second motor active while none");
  second_gate_a: assert property ((motor2_q != `MPS_NONE && sfs_q)
    |=> o_second_motor_active && o_motor_const_sel == $past(motor2_q[5:0]))
    else $error("second motor not applied");
  sfs_map_a: assert property ((term_lvl[0] && itfs_q[0] == `MPS_FN_SECOND)
    |=> o_second_function) else $error("second function not raised");
  boost_ct_a: assert property ((wr_m1 && m1_ok && i_auto_boost_rating
    && i_pwdata[5:0] == `MPS_MP_CT) |=> o_torque_boost_level == `MPS_BOOST_CT
    && o_dc_brake_voltage == `MPS_BRAKE_CT) else $error("boost not updated");
  lock_hold_a: assert property (s_locked_wr |=> $stable(motor1_q) && $stable(motor2_q)
    ##0 irq_stat_q[`MPS_IRQ_REJECT]) else $error("locked write took effect");
  prealarm_a: assert property (alarm_d ##1 alarm_d |-> o_thermal_prealarm)
    else $error("prealarm missing at threshold");
  reject_a: assert property (s_bad_m1 |=> $stable(motor1_q))
    else $error("illegal profile accepted");

endmodule
`default_nettype wire

// ---- test/mps_panel_model.sv ----
// Operator side model: drives the digital input terminal pins
`timescale 1ns/1ps
`default_nettype none
module mps_panel_model
(
  input  wire logic       i_clk,
  input  wire logic       i_second_req,
  input  wire logic       i_current_req,
  output logic      [4:0] o_terminal
);
  // Pin 0 carries second function (code 3), pin 1 current select (code 4)
  always_ff @(posedge i_clk)
  begin
    o_terminal <= {3'h0, i_current_req, i_second_req};
  end
endmodule
`default_nettype wire

// ---- test/mps_top_bench.sv ----
// Self-checking bench of the motor profile selector
`timescale 1ns/1ps
`default_nettype none
`include "mps_regs.svh"
module mps_top_bench;
  import mps_pkg::*;
  logic        clk, rst, psel, pen, pwr, ext, rate, sreq, areq, err;
  logic [7:0]  paddr;
  logic [31:0] pwd, rdat;
  logic [15:0] cum, cur1, cur2;
  logic [4:0]  term;
  logic [31:0] prdata;
  logic        pready, pslverr, t2, t4, sfn, sact, tune, alarm, irq;
  logic [1:0]  curve;
  logic [5:0]  sel, c;
  logic [7:0]  boost, brake;
  logic [15:0] ebb;
  logic [5:0]  codes [9] = '{6'h00, 6'h01, 6'h03, 6'h0d, 6'h17, 6'h28, 6'h2b, 6'h32, 6'h35};
  int          mismatches, num_checks, seed, k;

  mps_panel_model pnl_u (.i_clk(clk), .i_second_req(sreq), .i_current_req(areq),
    .o_terminal(term));
  mps_top dut_u (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_terminal(term), .i_external_mode(ext), .i_auto_boost_rating(rate),
    .i_thermal_cum(cum), .i_motor1_current(cur1), .i_motor2_current(cur2),
    .o_t2_freq_enable(t2), .o_t4_freq_enable(t4), .o_second_function(sfn),
    .o_second_motor_active(sact), .o_thermal_curve(curve), .o_motor_const_sel(sel),
    .o_autotune_profile(tune), .o_thermal_prealarm(alarm), .o_torque_boost_level(boost),
    .o_dc_brake_voltage(brake), .o_irq(irq));

  //----------------------------------------------------------------------------
  // Expectations
  //----------------------------------------------------------------------------
  function automatic logic [15:0] exp_bb(input logic [5:0] v);
    return (v == 6'h01 || v == 6'h0d || v == 6'h32 || v == 6'h35) ? 16'h0202 : 16'h0403;
  endfunction
  function automatic logic exp_tune(input logic [5:0] v);
    return v == 6'h03 || v == 6'h0d || v == 6'h17 || v == 6'h2b || v == 6'h35;
  endfunction
  function automatic logic [1:0] exp_cv(input logic [5:0] v);
    return (v == 6'h01) ? 2'h1 : (v == 6'h28) ? 2'h2 : (v == 6'h32) ? 2'h3 : 2'h0;
  endfunction

  //----------------------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Request held until pready is sampled high; no wait count assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      end_sim();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    tick(3);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), rdat, e);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #4000000;
    mismatches++;
    end_sim();
  end

  initial
  begin
    {rst, psel, pen, pwr, ext, rate, sreq, areq} = 8'h80;
    {paddr, pwd, cum, cur1, cur2} = '0;
    seed = 32'h999b;
    tick(8);
    rst <= 1'b0;
    rdchk(`MPS_A_MOTOR1, 32'h0);
    rdchk(`MPS_A_MOTOR2, 32'h270f);
    rdchk(`MPS_A_BOOST, 32'h0403);
    chk("t2", t2, 1'b1);
    ebb = 16'h0403;
    for (int i = 0; i < 9; i++)
    begin
      c = codes[i];
      rate <= 1'($random(seed));
      wr(`MPS_A_MOTOR1, {26'h0, c});
      if (rate)
        ebb = exp_bb(c);
      chk("sel", sel, c);
      chk("tune", tune, exp_tune(c));
      chk("boost", {brake, boost}, ebb);
      if (!exp_tune(c))
        chk("curve", curve, exp_cv(c));
    end
    rate <= 1'b1;
    wr(`MPS_A_MOTOR1, 32'h1);
    chk("boost", {brake, boost}, 16'h0202);
    wr(`MPS_A_MOTOR1, 32'h28);
    chk("boost", {brake, boost}, 16'h0403);
    wr(`MPS_A_MOTOR1, 32'h35);
    chk("boost", {brake, boost}, 16'h0202);
    wr(`MPS_A_MOTOR1, 32'h2);
    chk("sel", sel, 6'h35);
    chk("irq", irq, 1'b0);
    wr(`MPS_A_IRQMASK, 32'h1);
    chk("irq", irq, 1'b1);
    rdchk(`MPS_A_IRQSTAT, 32'h1);
    tick(2);
    chk("irq", irq, 1'b0);
    wr(`MPS_A_EXTDISP, 32'h1);
    wr(`MPS_A_MOTOR1, 32'h0);
    wr(`MPS_A_MOTOR2, 32'h0);
    chk("sel", sel, 6'h35);
    rdchk(`MPS_A_MOTOR2, 32'h270f);
    wr(`MPS_A_EXTDISP, 32'h0);
    wr(`MPS_A_MOTOR2, 32'h1);
    wr(`MPS_A_MOTOR2, 32'h5);
    rdchk(`MPS_A_MOTOR2, 32'h1);
    wr(`MPS_A_ITFS0, 32'h3);
    wr(`MPS_A_ITFS0 + 8'h04, 32'h4);
    sreq <= 1'b1;
    tick(8);
    chk("sfn", sfn, 1'b1);
    chk("sact", sact, 1'b1);
    chk("curve", curve, 2'h1);
    sreq <= 1'b0;
    tick(8);
    chk("sact", sact, 1'b0);
    wr(`MPS_A_THERM, 32'h64);
    chk("t2", t2, 1'b0);
    wr(`MPS_A_THERM, 32'h270f);
    wr(`MPS_A_PID, 32'h1);
    chk("t2", t2, 1'b0);
    wr(`MPS_A_PID, 32'h0);
    wr(`MPS_A_OPMODE, 32'h4);
    chk("t4", t4, 1'b1);
    wr(`MPS_A_OPMODE, 32'h0);
    ext <= 1'b1;
    tick(3);
    chk("t4", t4, 1'b1);
    ext <= 1'b0;
    wr(`MPS_A_OPMODE, 32'h3);
    chk("t4", t4, 1'b0);
    areq <= 1'b1;
    tick(8);
    chk("t4", t4, 1'b1);
    apb(1'b0, 8'h3c, 32'h0);
    chk("pslverr", err, 1'b1);
    chk("unmapped", rdat, 32'h0);
    chk("pready", pready, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      k = 1 + ($random(seed) & 31);
      cur1 <= 16'(100 * k);
      cur2 <= 16'($random(seed));
      cum <= 16'(85 * k - 1);
      tick(3);
      chk("alarm", alarm, 1'b0);
      cum <= 16'(85 * k);
      tick(3);
      chk("alarm", alarm, 1'b1);
    end
    // Mid-run reset: settings must return to their reset values
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    chk("sel", sel, 6'h00);
    chk("boost", {brake, boost}, 16'h0403);
    chk("irq", irq, 1'b0);
    rdchk(`MPS_A_MOTOR2, 32'h270f);
    end_sim();
  end
endmodule
`default_nettype wire
